// ===== pci_tfc_pkg.sv
// Constants and types shared by the PCI target function-control block
package pci_tfc_pkg;
  // ----------------------------------------------------------------
  // Configuration offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SELF_TEST_OFS = 8'h0F; // Self-test byte
  localparam logic [7:0] RSVD_LO_OFS = 8'h10; // First reserved byte
  localparam logic [7:0] RSVD_HI_OFS = 8'h3F; // Last reserved byte
  localparam logic [7:0] FC1_OFS = 8'h40; // Function control one
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SELF_TEST_RST = 8'h00; // Always zero
  localparam logic [7:0] FC1_RST = 8'h79; // Function control default
  // ----------------------------------------------------------------
  // Field positions in function control one
  // ----------------------------------------------------------------
  localparam int KEEP_BIT = 7; // Internal, software preserves
  localparam int SW_BIT = 6; // Single write mode
  localparam int SR_BIT = 5; // Single read mode
  localparam int RT_BIT = 4; // Retry while data buffered
  // ----------------------------------------------------------------
  // Bus commands (C/BE# in address phase)
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_MEM_RD = 4'h6; // Memory read
  localparam logic [3:0] CMD_MEM_WR = 4'h7; // Memory write
  localparam logic [3:0] CMD_CFG_RD = 4'hA; // Configuration read
  localparam logic [3:0] CMD_CFG_WR = 4'hB; // Configuration write
  // ----------------------------------------------------------------
  // Target sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle, st_claim, st_data, st_retry, st_end
  } tgt_state_t;
endpackage : pci_tfc_pkg

// ===== pci_target_function_control.sv
// PCI target with configuration bytes and function-control steering
`timescale 1ns/10ps
module pci_target_function_control #(
  parameter logic [31:0] MEM_BASE = 32'h0000_0000, // Memory window base
  parameter logic [31:0] MEM_MASK = 32'hFFFF_0000 // Window compare mask
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic frame_n, // Bus FRAME#
  input wire logic irdy_n, // Bus IRDY#
  input wire logic idsel, // Configuration select
  input wire logic [31:0] ad_in, // AD as seen on the bus
  input wire logic [3:0] cbe_n, // C/BE# as seen on the bus
  output logic [31:0] ad_out, // Read data driven onto AD
  output logic ad_oe, // AD drive enable
  output logic trdy_n, // Bus TRDY#
  output logic stop_n, // Bus STOP#
  output logic devsel_n, // Bus DEVSEL#
  output logic tgt_oe, // Drive enable for TRDY#, STOP#, DEVSEL#
  input wire logic buf_pending, // Buffered data still waiting
  output logic wr_strobe, // One-cycle write beat to the far side
  output logic [31:0] wr_addr, // Write beat address
  output logic [31:0] wr_data, // Write beat data
  output logic [31:0] rd_addr, // Address of the read being fetched
  input wire logic [31:0] rd_data // Read data for rd_addr
);
  import pci_tfc_pkg::*;

  // ----------------------------------------------------------------
  // Configuration read decode
  // ----------------------------------------------------------------
  // Dword read value for a configuration offset
  function automatic logic [31:0] cfg_read(input logic [5:0] dw,
                                           input logic [7:0] fc1);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (dw == SELF_TEST_OFS[7:2]) begin
      v = {SELF_TEST_RST, 24'h00_0000};
    end else if (dw == FC1_OFS[7:2]) begin
      v = {24'h00_0000, fc1};
    end
    // Reserved 10h-3Fh and out-of-scope bytes fall through to zero
    return v;
  endfunction : cfg_read

  // ----------------------------------------------------------------
  // State and latched cycle attributes
  // ----------------------------------------------------------------
  tgt_state_t state_r; // Sequencer state
  logic [7:0] fc1_r; // Function control one
  logic [31:0] addr_r; // Current beat address
  logic cyc_cfg_r; // Cycle is configuration
  logic cyc_wr_r; // Cycle is a write
  logic [31:0] ad_out_r; // Registered read data
  logic ad_oe_r; // Registered AD enable
  logic trdy_n_r; // Registered TRDY#
  logic stop_n_r; // Registered STOP#
  logic devsel_n_r; // Registered DEVSEL#
  logic tgt_oe_r; // Registered control enable
  logic wr_strobe_r; // Registered write beat
  logic [31:0] wr_addr_r; // Registered write address
  logic [31:0] wr_data_r; // Registered write data
  logic seen_r; // Set after the first clock out of reset

  logic [3:0] cmd; // Address-phase command
  logic cfg_hit; // Configuration cycle for us
  logic mem_hit; // Memory cycle in our window
  logic addr_phase; // Address phase seen while idle
  logic xfer; // Data phase completes this edge
  logic single; // Disconnect after the first beat

  assign cmd = cbe_n;
  assign cfg_hit = idsel && (ad_in[1:0] == 2'b00) &&
                   (cmd == CMD_CFG_RD || cmd == CMD_CFG_WR);
  assign mem_hit = ((ad_in & MEM_MASK) == MEM_BASE) &&
                   (cmd == CMD_MEM_RD || cmd == CMD_MEM_WR);
  assign addr_phase = (state_r == st_idle) && !frame_n;
  assign xfer = (state_r == st_data) && !irdy_n && !trdy_n_r;
  // Configuration cycles are always single beat
  assign single = cyc_cfg_r ||
                  (cyc_wr_r ? fc1_r[SW_BIT] : fc1_r[SR_BIT]);

  // ----------------------------------------------------------------
  // Target sequencer and bus handshake
  // ----------------------------------------------------------------
  // Claims, inserts a fetch wait, answers beats, retries, turns round
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= st_idle;
      addr_r <= 32'h0000_0000;
      cyc_cfg_r <= 1'b0;
      cyc_wr_r <= 1'b0;
      trdy_n_r <= 1'b1;
      stop_n_r <= 1'b1;
      devsel_n_r <= 1'b1;
      tgt_oe_r <= 1'b0;
      ad_oe_r <= 1'b0;
      ad_out_r <= 32'h0000_0000;
    end else begin
      unique case (state_r)
        st_idle: begin
          // Claim on a matching address phase
          if (addr_phase && (cfg_hit || mem_hit)) begin
            addr_r <= ad_in;
            cyc_cfg_r <= cfg_hit;
            cyc_wr_r <= cmd[0];
            devsel_n_r <= 1'b0;
            tgt_oe_r <= 1'b1;
            if (mem_hit && fc1_r[RT_BIT] && buf_pending) begin
              stop_n_r <= 1'b0;
              state_r <= st_retry;
            end else begin
              state_r <= st_claim;
            end
          end
        end
        st_claim: begin
          // Present the beat; rd_data answers rd_addr this cycle
          trdy_n_r <= 1'b0;
          stop_n_r <= !single;
          ad_oe_r <= !cyc_wr_r;
          ad_out_r <= cyc_cfg_r ? cfg_read(addr_r[7:2], fc1_r) : rd_data;
          state_r <= st_data;
        end
        st_data: begin
          if (xfer) begin
            addr_r <= addr_r + 32'h0000_0004;
            if (!stop_n_r || frame_n) begin
              // Disconnect with data, or last beat of a burst
              trdy_n_r <= 1'b1;
              stop_n_r <= 1'b1;
              devsel_n_r <= 1'b1;
              state_r <= st_end;
            end else if (!cyc_wr_r) begin
              // Read burst: one wait state to fetch the next word
              trdy_n_r <= 1'b1;
              state_r <= st_claim;
            end
          end else if (frame_n && irdy_n) begin
            // Initiator gave up
            trdy_n_r <= 1'b1;
            stop_n_r <= 1'b1;
            devsel_n_r <= 1'b1;
            state_r <= st_end;
          end
        end
        st_retry: begin
          // Hold STOP# until the initiator drops FRAME#
          if (frame_n) begin
            stop_n_r <= 1'b1;
            devsel_n_r <= 1'b1;
            state_r <= st_end;
          end
        end
        st_end: begin
          // Drive high for one cycle, then release
          tgt_oe_r <= 1'b0;
          ad_oe_r <= 1'b0;
          state_r <= st_idle;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  // Only function control one is writable; all else is ignored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fc1_r <= FC1_RST;
    end else if (xfer && cyc_cfg_r && cyc_wr_r &&
                 addr_r[7:2] == FC1_OFS[7:2] && !cbe_n[0]) begin
      // Top bit stored as written; software writes it back
      fc1_r <= ad_in[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Far-side data path
  // ----------------------------------------------------------------
  // Write beats go out as one-cycle strobes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_strobe_r <= 1'b0;
      wr_addr_r <= 32'h0000_0000;
      wr_data_r <= 32'h0000_0000;
    end else begin
      wr_strobe_r <= xfer && cyc_wr_r && !cyc_cfg_r;
      if (xfer && cyc_wr_r && !cyc_cfg_r) begin
        wr_addr_r <= addr_r;
        wr_data_r <= ad_in;
      end
    end
  end

  // Reset-release marker for checks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seen_r <= 1'b0;
    end else begin
      seen_r <= 1'b1;
    end
  end

  assign ad_out = ad_out_r;
  assign ad_oe = ad_oe_r;
  assign trdy_n = trdy_n_r;
  assign stop_n = stop_n_r;
  assign devsel_n = devsel_n_r;
  assign tgt_oe = tgt_oe_r;
  assign wr_strobe = wr_strobe_r;
  assign wr_addr = wr_addr_r;
  assign wr_data = wr_data_r;
  assign rd_addr = addr_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  self_test_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (!trdy_n_r && ad_oe_r && cyc_cfg_r &&
     addr_r[7:2] == SELF_TEST_OFS[7:2]) |-> ad_out_r[31:24] == 8'h00)
    else $error("self-test byte not zero");
  single_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == st_claim && cyc_wr_r && fc1_r[SW_BIT]) |=>
    (!trdy_n_r && !stop_n_r))
    else $error("single write without disconnect");
  burst_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (xfer && cyc_wr_r && !cyc_cfg_r && !fc1_r[SW_BIT] && !frame_n) |=>
    (state_r == st_data && !trdy_n_r && stop_n_r))
    else $error("burst write not accepted");
  single_read_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == st_claim && !cyc_wr_r && fc1_r[SR_BIT]) |=>
    (!trdy_n_r && !stop_n_r) ##1 (trdy_n_r || state_r == st_data))
    else $error("single read without disconnect");
  retry_on_a: assert property (@(posedge clk) disable iff (!nrst)
    (addr_phase && mem_hit && fc1_r[RT_BIT] && buf_pending) |=>
    (!stop_n_r && trdy_n_r && !devsel_n_r))
    else $error("no retry while data buffered");
  retry_off_a: assert property (@(posedge clk) disable iff (!nrst)
    (addr_phase && mem_hit && !fc1_r[RT_BIT]) |=>
    stop_n_r ##1 !trdy_n_r)
    else $error("retry while retry disabled");
  reset_value_a: assert property (@(posedge clk) disable iff (!nrst)
    !seen_r |-> fc1_r == FC1_RST)
    else $error("function control reset value wrong");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (!trdy_n_r && ad_oe_r && cyc_cfg_r &&
     addr_r[7:0] >= RSVD_LO_OFS && addr_r[7:0] <= RSVD_HI_OFS) |->
    ad_out_r == 32'h0000_0000)
    else $error("reserved config space not zero");
endmodule : pci_target_function_control

// ===== far_side_model.sv
// Far-side model: sinks write beats and sources read words
`timescale 1ns/10ps
module far_side_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr_strobe,
  input wire logic [31:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [31:0] rd_addr,
  output logic [31:0] rd_data,
  output int n_wr
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] mem_r [16]; // Word store, indexed by address
  // Word for the fetched address, presented at once
  assign rd_data = mem_r[rd_addr[5:2]];
  // Capture each write beat and count it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      n_wr <= 0;
    end else if (wr_strobe) begin
      mem_r[wr_addr[5:2]] <= wr_data;
      n_wr <= n_wr + 1;
    end
  end
endmodule : far_side_model

// ===== pci_target_function_control_tb.sv
// Testbench for the PCI target function-control block
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("FAIL %0t got %h exp %h", $time, g, e); end end
module pci_target_function_control_tb;
  import pci_tfc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, nrst, frame_n, irdy_n, idsel, buf_pending;
  logic [31:0] m_ad, ad_in, ad_out, wr_addr, wr_data, rd_addr, rd_data;
  logic [3:0] cbe_n;
  logic ad_oe, trdy_n, stop_n, devsel_n, tgt_oe, wr_strobe;
  logic [31:0] got [2]; // Read words of the last transfer
  logic stp, rty; // Disconnect at first beat, retry seen
  int n_wr, fail_count, n_tests, w0;
  // AD wire: target drives when enabled, else the initiator
  assign ad_in = ad_oe ? ad_out : m_ad;
  // Clock at 50 MHz
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  pci_target_function_control dut_u (.clk(clk), .nrst(nrst),
    .frame_n(frame_n), .irdy_n(irdy_n), .idsel(idsel), .ad_in(ad_in),
    .cbe_n(cbe_n), .ad_out(ad_out), .ad_oe(ad_oe), .trdy_n(trdy_n),
    .stop_n(stop_n), .devsel_n(devsel_n), .tgt_oe(tgt_oe),
    .buf_pending(buf_pending), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data));
  far_side_model far_u (.clk(clk), .nrst(nrst), .wr_strobe(wr_strobe),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
    .rd_data(rd_data), .n_wr(n_wr));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Verdict and end of run
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  // One initiator transaction of n beats, data wd, wd+1, ...
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] a,
    input int n, input logic [3:0] be, input logic [31:0] wd);
    int b, k;
    b = 0;
    rty = 0;
    stp = 0;
    @(negedge clk);
    frame_n = 0;
    idsel = cmd[3];
    cbe_n = cmd;
    m_ad = a;
    @(negedge clk);
    frame_n = (n == 1);
    irdy_n = 0;
    cbe_n = be;
    m_ad = cmd[0] ? wd : ~a;
    for (k = 0; k < 40 && b < n && !rty; k++) begin
      // Outputs are settled at the falling edge; a low TRDY# here is
      // taken at the next rising edge, so the phase moves on after it
      if (!trdy_n) begin
        // Beat taken: record, then move to next phase
        got[b] = ad_out;
        if (b == 0) stp = !stop_n;
        `CHK(devsel_n, 1'b0)
        b++;
        @(negedge clk);
        frame_n = (b >= n - 1);
        irdy_n = (b == n);
        m_ad = cmd[0] ? wd + b : ~a;
      end else if (!stop_n) begin
        // Target refused: end the cycle
        rty = 1;
        `CHK({devsel_n, trdy_n}, 2'b01)
        @(negedge clk);
        frame_n = 1;
      end else begin
        // No answer yet: look again at the next falling edge
        @(negedge clk);
      end
    end
    if (b < n && !rty) begin
      fail_count++;
      wrap_up();
    end
    @(negedge clk);
    irdy_n = 1;
    idsel = 0;
    cbe_n = 4'hF;
    for (k = 0; k < 10 && tgt_oe !== 1'b0; k++) @(negedge clk);
    if (tgt_oe !== 1'b0) begin
      fail_count++;
      wrap_up();
    end
  endtask : xfer
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, idsel, buf_pending} = 3'h0;
    {frame_n, irdy_n, cbe_n, m_ad} = {2'h3, 4'hF, 32'h0};
    repeat (10) @(negedge clk);
    nrst = 1;
    // Reset values and read-only self-test byte
    xfer(CMD_CFG_RD, 32'h40, 1, 4'h0, 0);
    `CHK(got[0], {24'h0, FC1_RST})
    xfer(CMD_CFG_WR, 32'h0C, 1, 4'h7, 32'hFF00_0000);
    xfer(CMD_CFG_RD, 32'h0C, 1, 4'h0, 0);
    `CHK(got[0], 32'h0)
    // Reserved range reads zero, writes are dropped
    for (w0 = 'h10; w0 <= 'h3C; w0 += 'h2C) begin
      xfer(CMD_CFG_WR, w0, 1, 4'h0, 32'hFFFF_FFFF);
      xfer(CMD_CFG_RD, w0, 1, 4'h0, 0);
      `CHK(got[0], 32'h0)
    end
    xfer(CMD_CFG_RD, 32'h40, 1, 4'h0, 0);
    `CHK(got[0], {24'h0, FC1_RST})
    $display("test defaults done");
    // Default single modes: disconnect at first beat
    xfer(CMD_MEM_WR, 32'h108, 1, 4'h0, 32'h1234_5678);
    `CHK(stp, 1'b1)
    xfer(CMD_MEM_RD, 32'h108, 1, 4'h0, 0);
    `CHK(stp, 1'b1)
    `CHK(got[0], 32'h1234_5678)
    // Retry while data waits, nothing is written
    buf_pending = 1;
    w0 = n_wr;
    xfer(CMD_MEM_WR, 32'h108, 1, 4'h0, 32'h0);
    `CHK(rty, 1'b1)
    `CHK(n_wr, w0)
    xfer(CMD_MEM_RD, 32'h108, 1, 4'h0, 0);
    `CHK(rty, 1'b1)
    $display("test single and retry done");
    // Clear modes, keeping the top bit as read
    xfer(CMD_CFG_RD, 32'h40, 1, 4'h0, 0);
    xfer(CMD_CFG_WR, 32'h40, 1, 4'hE, got[0] & 32'h8F);
    xfer(CMD_CFG_RD, 32'h40, 1, 4'h0, 0);
    `CHK(got[0], {24'h0, FC1_RST & 8'h8F})
    // Bursts accepted, no retry with data pending
    xfer(CMD_MEM_WR, 32'h100, 2, 4'h0, 32'hA5A5_0000);
    `CHK({rty, stp}, 2'b00)
    `CHK(far_u.mem_r[1], 32'hA5A5_0001)
    xfer(CMD_MEM_RD, 32'h100, 2, 4'h0, 0);
    `CHK({rty, stp}, 2'b00)
    `CHK(got[0], 32'hA5A5_0000)
    `CHK(got[1], 32'hA5A5_0001)
    $display("test bursts done");
    // Reset in mid-run brings the default modes back
    nrst = 0;
    repeat (3) @(negedge clk);
    nrst = 1;
    xfer(CMD_CFG_RD, 32'h40, 1, 4'h0, 0);
    `CHK(got[0], {24'h0, FC1_RST})
    $display("test reset done");
    wrap_up();
  end
endmodule : pci_target_function_control_tb
